// file: sar_host_end.sv
// host end: serial master that frames one conversion and collects the result
`timescale 1ns/1ps
module sar_host_end #(
   parameter int RES_W     = sar_pkg::RES_W_DEF,
   parameter int HALF_CYC  = sar_pkg::SCLK_HALF_CYC,
   parameter int QUIET_CYC = sar_pkg::QUIET_CYC
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   sar_link_if.host              link,
   input  wire logic             start,
   input  wire logic             abort,
   output logic                  ready,
   output logic [RES_W-1:0]      result,
   output logic                  result_valid
);
   // =====================================================================
   // geometry
   localparam int FRAME = RES_W + sar_pkg::LEAD_ZEROS;
   localparam int BW    = $clog2(FRAME + 1);
   localparam int TW    = $clog2(((HALF_CYC > QUIET_CYC) ? HALF_CYC : QUIET_CYC) + 1);

   localparam logic [BW-1:0] FRAME_C = BW'(FRAME);
   localparam logic [TW-1:0] HALF_C  = TW'(HALF_CYC - 1);
   localparam logic [TW-1:0] QUIET_C = TW'(QUIET_CYC - 1);

   typedef enum logic [4:0] {
      IDLE  = 5'b00001,
      LEAD  = 5'b00010,
      HIGH  = 5'b00100,
      LOW   = 5'b01000,
      QUIET = 5'b10000
   } state_t;

   state_t           state_q;
   state_t           state_d;
   logic [TW-1:0]    tmr_q;
   logic [BW-1:0]    falls_q;
   logic [FRAME-1:0] shift_q;
   logic             sdo_s;
   logic             cs_n_q;
   logic             sclk_q;
   logic             valid_q;
   logic [RES_W-1:0] result_q;

   // =====================================================================
   // data input crosses into mclk before use
   sar_sync2 u_sdo_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (link.sdo_line),
      .q     (sdo_s)
   );

   // =====================================================================
   // decode
   wire half_end  = (tmr_q == HALF_C);
   wire quiet_end = (tmr_q == QUIET_C);
   // the frame ends only after the last counted fall, so the converter
   // sees every edge and the final bit is read on the last rising edge
   wire last_fall = (falls_q == FRAME_C);
   wire sample    = (state_q == HIGH) && (tmr_q == '0);

   // (R10) new frame only after quiet time
   assign ready = (state_q == IDLE);

   always_comb begin
      state_d = state_q;
      case (state_q)
         IDLE:  if (start) state_d = LEAD;
         LEAD:  if (half_end) state_d = HIGH;
         HIGH:  if (abort) state_d = QUIET;
                else if (half_end) state_d = LOW;
         LOW:   if (abort) state_d = QUIET;
                else if (half_end) state_d = last_fall ? QUIET : HIGH;
         QUIET: if (quiet_end) state_d = IDLE;
         default: state_d = IDLE;
      endcase
   end

   // =====================================================================
   // sequencing
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= IDLE;
         tmr_q   <= '0;
         falls_q <= '0;
      end else begin
         state_q <= state_d;
         tmr_q   <= (state_d != state_q) ? '0 : tmr_q + TW'(1);
         falls_q <= (state_q == IDLE) ? '0 :
                    (state_d == LOW && state_q == HIGH) ? falls_q + BW'(1) : falls_q;
      end
   end

   // =====================================================================
   // link pins; sclk idles low so the first edge is a rising one
   // (R08) select raised after each frame, so the next frame opens with a select fall
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cs_n_q <= 1'b1;
         sclk_q <= 1'b0;
      end else begin
         cs_n_q <= !(state_d == LEAD || state_d == HIGH || state_d == LOW);
         sclk_q <= (state_d == HIGH);
      end
   end

   assign link.cs_n = cs_n_q;
   assign link.sclk = sclk_q;

   // =====================================================================
   // capture; the bit read at each rising edge left the device one half
   // period earlier, which covers the two-flop delay of the synchroniser
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         shift_q  <= '0;
         result_q <= '0;
         valid_q  <= 1'b0;
      end else begin
         shift_q  <= sample ? {shift_q[FRAME-2:0], sdo_s} : shift_q;
         valid_q  <= (state_q == LOW) && half_end && last_fall && !abort;
         result_q <= valid_q ? shift_q[RES_W-1:0] : result_q;
      end
   end

   assign result       = result_q;
   assign result_valid = valid_q;
endmodule

// file: sar_pkg.sv
// shared constants for the conversion sequencer and its host serial master
package sar_pkg;
   // =====================================================================
   // frame layout
   localparam int LEAD_ZEROS     = 4;
   localparam int HOLD_EDGE      = 3;
   localparam int RES_W_DEF      = 12;
   // =====================================================================
   // host timing
   localparam int MCLK_PERIOD_NS = 10;
   localparam int QUIET_NS       = 50;
   // least time, rounded up to whole cycles
   localparam int QUIET_CYC      = (QUIET_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int SCLK_HALF_CYC  = 4;
endpackage

// file: sar_link_if.sv
// serial link between the converter sequencer and the host master
`timescale 1ns/1ps
interface sar_link_if;
   logic sclk;
   logic cs_n;
   logic sdo;
   logic sdo_oe;
   logic sdo_line;

   // released line reads high, as with a weak pull-up
   assign sdo_line = sdo_oe ? sdo : 1'b1;

   modport device (
      input  sclk,
      input  cs_n,
      output sdo,
      output sdo_oe
   );

   modport host (
      output sclk,
      output cs_n,
      input  sdo_line
   );
endinterface

// file: sar_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sar_sync2 (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic d,
   output logic      q
);
   logic meta_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         q      <= 1'b1;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// file: sar_device_end.sv
// converter end: conversion and power-down sequencer clocked by the serial clock
//
// Overview of operation
// (R01) select falling wakes part, tracks, starts conversion
// (R02) hold kept throughout power-down until select falls
// (R03) third falling clock edge returns to hold
// (R04) 12-bit: 16 clocks, power-down on 16th
// (R05) 10-bit: 14 clocks, power-down on 14th
// (R06) 8-bit: 12 clocks, power-down on 12th
// (R07) early select rise aborts, releases data, sleeps
// (R08) host may idle select either way
// (R09) host runs one dummy conversion after power-up
// (R10) host restarts only after release plus quiet
// (R11) all conversion timing taken from serial clock
// (R12) four leading zeros then result, msb first
// (R13) select falling enables the data output
// (R14) first zero at select fall, then shift
// (R15) one width parameter sets edge count
`timescale 1ns/1ps
module sar_device_end #(
   parameter int RES_W = sar_pkg::RES_W_DEF
) (
   sar_link_if.device           link,
   input  wire logic [RES_W-1:0] conv_value,
   output logic                  track,
   output logic                  awake
);
   // =====================================================================
   // frame geometry
   // (R15) width sets count
   localparam int FRAME = RES_W + sar_pkg::LEAD_ZEROS;
   localparam int CW    = $clog2(FRAME + 1);

   localparam logic [CW-1:0] FRAME_C = CW'(FRAME);
   localparam logic [CW-1:0] HOLD_C  = CW'(sar_pkg::HOLD_EDGE);
   localparam logic [CW-1:0] LEAD_C  = CW'(sar_pkg::LEAD_ZEROS);
   localparam logic [CW-1:0] ONE_C   = CW'(1);

   // =====================================================================
   // state, all on the serial clock
   logic [CW-1:0]    edges_q;
   logic [CW-1:0]    edges_d;
   logic [RES_W-1:0] sr_q;
   logic [RES_W-1:0] sr_d;
   logic             bit_q;
   logic             bit_d;

   // =====================================================================
   // decode
   // (R04) (R05) (R06) final edge count
   wire frame_done  = (edges_q == FRAME_C);
   wire selected    = !link.cs_n;
   wire take_sample = !frame_done && (edges_d == HOLD_C);
   wire in_result   = !frame_done && (edges_d >= LEAD_C);

   // (R11) timing from edge count
   assign edges_d = frame_done ? edges_q : edges_q + ONE_C;

   // (R12) zeros then msb first
   assign bit_d = in_result ? sr_q[RES_W-1] : 1'b0;

   // result is captured as the hold edge closes the sample window
   assign sr_d = take_sample ? conv_value :
                 in_result   ? {sr_q[RES_W-2:0], 1'b0} :
                               sr_q;

   // =====================================================================
   // sequencer
   // the serial clock may stop once select rises, so select itself
   // clears the frame; no later clock edge is needed to go to sleep
   // (R07) select rise aborts
   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         edges_q <= '0;
         sr_q    <= '0;
         bit_q   <= 1'b0;
      end else begin
         // (R14) shift next bit
         edges_q <= edges_d;
         sr_q    <= sr_d;
         bit_q   <= bit_d;
      end
   end

   // =====================================================================
   // outputs
   // (R01) (R02) track only from select fall
   // (R03) hold at third edge
   assign track = selected && (edges_q < HOLD_C);

   // (R04) (R05) (R06) sleep on final edge
   assign awake = selected && !frame_done;

   // (R13) output enabled by select
   assign link.sdo_oe = awake;

   // first leading zero is already present when select falls
   assign link.sdo = bit_q;
endmodule

// file: sar_link_chk.sv
// link assertions between host end and converter end
`timescale 1ns/1ps
module sar_link_chk #(
   parameter int RES_W = sar_pkg::RES_W_DEF
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdo,
   input wire logic sdo_oe
);
   // =========================================
   // falling-edge count, as the converter sees it
   localparam int FRAME = RES_W + sar_pkg::LEAD_ZEROS;
   logic       sclk_q;
   logic [4:0] falls_q;
   logic [4:0] falls_w;
   wire        fell_w = sclk_q & ~sclk;
   // saturates like the converter, which ignores late edges
   assign falls_w = (falls_q == 5'(FRAME)) ? falls_q : falls_q + 5'(fell_w);
   always_ff @(posedge mclk) begin
      sclk_q  <= sclk;
      falls_q <= cs_n ? 5'h00 : falls_w;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence seq_select;
      $fell(cs_n);
   endsequence
   sequence seq_frame_out;
      sdo_oe [*8] ##[1:300] !sdo_oe;
   endsequence
   AST_OE_ON_SELECT: assert property (seq_select |-> sdo_oe && !sdo)
      else $error("data not driven at select");
   AST_FRAME_ENDS: assert property (seq_select |-> seq_frame_out)
      else $error("frame did not end");
   AST_OE_HELD: assert property (!cs_n && falls_w < FRAME |-> sdo_oe)
      else $error("data released early");
   AST_OE_OFF_LAST: assert property (!cs_n && falls_w == FRAME |-> !sdo_oe)
      else $error("data held past last edge");
   AST_OE_OFF_DESELECT: assert property (cs_n |-> !sdo_oe)
      else $error("data driven while deselected");
   AST_LEAD_ZEROS: assert property (sdo_oe && falls_w < sar_pkg::LEAD_ZEROS |-> !sdo)
      else $error("leading bit not zero");
   AST_BIT_STEADY: assert property (sdo_oe && $past(sdo_oe) && !fell_w |-> $stable(sdo))
      else $error("bit moved off a falling edge");
   AST_QUIET_GAP: assert property ($rose(cs_n) |-> cs_n [*5])
      else $error("select lowered inside quiet time");
endmodule

// file: tb_sar_adc_conversion_sequencer.sv
// bench: three width variants, each host end facing a converter end
`timescale 1ns/1ps
module tb_sar_adc_conversion_sequencer;
   // =========================================
   // three variants share stimulus
   logic        mclk;
   logic        rst_n;
   logic        start;
   logic        abort;
   logic [11:0] conv_value;
   logic [2:0]  rdy;
   logic [2:0]  trk;
   logic [2:0]  awk;
   logic [2:0]  rv;
   logic [11:0] exp_q [3][$];
   int          error_cnt;
   int          num_checks;
   int          cycles;
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input logic [11:0] seen, input logic [11:0] want);
      num_checks++;
      if (seen !== want) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   for (genvar g = 0; g < 3; g++) begin : variant
      localparam int W = 12 - 2 * g;
      logic [W-1:0] res;
      logic         seen_q;
      sar_link_if sar_link_if_inst ();
      sar_device_end #(.RES_W(W)) sar_device_end_inst (.link(sar_link_if_inst), .conv_value(conv_value[W-1:0]),
         .track(trk[g]), .awake(awk[g]));
      sar_host_end #(.RES_W(W)) sar_host_end_inst (.mclk(mclk), .rst_n(rst_n), .link(sar_link_if_inst),
         .start(start), .abort(abort), .ready(rdy[g]), .result(res), .result_valid(rv[g]));
      if (g == 0) begin : chk
         sar_link_chk #(.RES_W(W)) sar_link_chk_inst (.mclk(mclk), .rst_n(rst_n), .sclk(sar_link_if_inst.sclk),
            .cs_n(sar_link_if_inst.cs_n), .sdo(sar_link_if_inst.sdo), .sdo_oe(sar_link_if_inst.sdo_oe));
      end
      // result lands one cycle after its pulse
      always @(negedge mclk) begin
         if (seen_q) begin
            if (exp_q[g].size() == 0) check(12'h000, 12'hFFF);
            else check(12'(res), exp_q[g].pop_front());
         end
         if (rst_n && sar_link_if_inst.cs_n) check(12'({trk[g], awk[g]}), 12'h000);
         seen_q <= rst_n & rv[g];
      end
   end
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (rdy !== 3'b111 && n < 500);
   endtask
   task automatic frame(input logic [11:0] value, input bit cut);
      wait_ready();
      conv_value = value;
      start = 1'b1;
      if (!cut) for (int g = 0; g < 3; g++) exp_q[g].push_back(value & (12'hFFF >> (2 * g)));
      @(posedge mclk);
      #1;
      start = 1'b0;
      repeat (2) @(posedge mclk);
      check(12'({trk, awk}), 12'h03F);
      repeat (28) @(posedge mclk);
      check(12'({trk, awk}), 12'h007);
      if (cut) begin
         repeat (10) @(posedge mclk);
         #1;
         abort = 1'b1;
         @(posedge mclk);
         #1;
         abort = 1'b0;
      end
      $display("test done value %h cut %0d", value, cut);
   endtask
   task automatic stop_test();
      for (int g = 0; g < 3; g++) check(12'(exp_q[g].size()), 12'h000);
      $display("comparisons %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // limit covers ten frames with ample margin
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      rst_n = 1'b0;
      start = 1'b0;
      abort = 1'b0;
      conv_value = 12'h000;
      error_cnt = 0;
      num_checks = 0;
      cycles = 0;
      void'($urandom(32'h8E32B02B));
      repeat (4) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      // first frame doubles as the power-up dummy conversion
      frame(12'h000, 1'b0);
      frame(12'hFFF, 1'b0);
      frame(12'h5A5, 1'b1);
      frame(12'hA5A, 1'b0);
      for (int i = 0; i < 6; i++) frame(12'($urandom), 1'b0);
      wait_ready();
      repeat (3) @(posedge mclk);
      stop_test();
   end
endmodule
